// *** hw/timer_status_regs.sv ***
// Register slave for one timer channel: status, interrupt flags, interrupt
// enables and the comparator/capture control words, on AXI4-Lite.
// Assumes all inputs are synchronous to aclk and events are one-cycle pulses.
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
module timer_status_regs #(
  parameter int NUM_CC  = 6,
  parameter int NUM_CAP = 6
) (
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  input  wire logic                              clk_en,
  input  wire logic [tmr_status_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [tmr_status_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [31:0]                            s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  input  wire tmr_status_pkg::status_in_s        status_in,
  input  wire tmr_status_pkg::events_s           events,
  output tmr_status_pkg::cc_ctrl_s [NUM_CC-1:0]  cc_control,
  output logic                                   irq
);

  // ****************************************************************
  // Elaboration checks and derived constants
  // ****************************************************************
  if (NUM_CC < 1 || NUM_CC > tmr_status_pkg::MAX_CC) begin : g_bad_cc
    $error("NUM_CC must lie between 1 and 6");
  end
  if (NUM_CAP < 0 || NUM_CAP > tmr_status_pkg::MAX_CC) begin : g_bad_cap
    $error("NUM_CAP must lie between 0 and 6");
  end

  localparam logic [tmr_status_pkg::FLAG_W-1:0] PRESENT = tmr_status_pkg::present_mask(NUM_CC);
  localparam logic [5:0] CAP_MASK = 6'(~(6'h3F << NUM_CAP));

  // Maps a byte address to a register select code, or the unmapped code.
  function automatic logic [3:0] addr_sel(input logic [tmr_status_pkg::ADDR_W-1:0] a);
    logic [3:0] s;
    s = tmr_status_pkg::SEL_UNMAPPED;
    if (a == tmr_status_pkg::OFS_STATUS) begin
      s = 4'h0;
    end else if (a == tmr_status_pkg::OFS_FLAGS) begin
      s = 4'h1;
    end else if (a == tmr_status_pkg::OFS_ENABLES) begin
      s = 4'h2;
    end
    for (int m = 0; m < NUM_CC; m++) begin
      if (a == tmr_status_pkg::OFS_CC_BASE + 12'(4*m)) begin
        s = 4'(4 + m);
      end
    end
    return s;
  endfunction : addr_sel

  // Merges the two low byte lanes of a write into a 16-bit register.
  function automatic logic [15:0] merge_lanes(input logic [15:0] old_v, input logic [31:0] wd,
                                              input logic [3:0] st);
    logic [15:0] v;
    v = old_v;
    if (st[0]) begin
      v[7:0] = wd[7:0];
    end
    if (st[1]) begin
      v[15:8] = wd[15:8];
    end
    return v;
  endfunction : merge_lanes

  // ****************************************************************
  // Write channel
  // ****************************************************************
  logic                              aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [tmr_status_pkg::ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0]                       wdata_q, wdata_d;
  logic [3:0]                        wstrb_q, wstrb_d;
  logic                              awready_d, wready_d, bvalid_d;
  logic [1:0]                        bresp_d;
  logic                              do_write;
  logic [3:0]                        wsel;

  // Address and data are taken in either order; the write lands once both are held.
  always_comb begin
    aw_held_d = aw_held_q;
    awaddr_d  = awaddr_q;
    w_held_d  = w_held_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = s_axi_bvalid;
    bresp_d   = s_axi_bresp;
    do_write  = 1'b0;
    wsel      = addr_sel(awaddr_q);
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_held_q && w_held_q && !s_axi_bvalid) begin
      do_write  = 1'b1;
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (wsel == tmr_status_pkg::SEL_UNMAPPED) ? tmr_status_pkg::RESP_SLVERR
                                                         : tmr_status_pkg::RESP_OKAY;
    end
    awready_d = !aw_held_d && !bvalid_d;
    wready_d  = !w_held_d && !bvalid_d;
  end

  // Write channel registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= tmr_status_pkg::RESP_OKAY;
    end else if (clk_en) begin
      aw_held_q     <= aw_held_d;
      w_held_q      <= w_held_d;
      awaddr_q      <= awaddr_d;
      wdata_q       <= wdata_d;
      wstrb_q       <= wstrb_d;
      s_axi_awready <= awready_d;
      s_axi_wready  <= wready_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_bresp   <= bresp_d;
    end
  end

  // ****************************************************************
  // Status snapshot, enables and control words
  // ****************************************************************
  logic [15:0]                                status_q, status_d;
  logic [tmr_status_pkg::FLAG_W-1:0]          enables_q, enables_d;
  tmr_status_pkg::cc_ctrl_s [NUM_CC-1:0]      cc_d;
  logic [tmr_status_pkg::FLAG_W-1:0]          flags_q;
  logic [15:0]                                wr_lane;
  logic [15:0]                                en_merge;

  // The status word is resampled every cycle, so a read shows the levels one
  // cycle old; this buys a clean flop boundary at the cost of one cycle.
  always_comb begin
    status_d = 16'h0000;
    status_d[tmr_status_pkg::POS_CAP_LEVEL +: 6] = status_in.capture_input_pin & CAP_MASK;
    status_d[tmr_status_pkg::POS_DIRECTION]      = status_in.count_up;
    status_d[tmr_status_pkg::POS_RUNNING]        = status_in.counter_running;
  end

  // Software writes to enables and control words; the status word ignores writes.
  always_comb begin
    enables_d = enables_q;
    cc_d      = cc_control;
    wr_lane   = merge_lanes(16'h0000, wdata_q, wstrb_q);
    en_merge  = merge_lanes({2'b00, enables_q}, wdata_q, wstrb_q);
    if (do_write && wsel == 4'h2) begin
      enables_d = en_merge[tmr_status_pkg::FLAG_W-1:0] & PRESENT;
    end
    for (int m = 0; m < NUM_CC; m++) begin
      if (do_write && wsel == 4'(4 + m)) begin
        cc_d[m] = merge_lanes(cc_control[m], wdata_q, wstrb_q);
        cc_d[m].reserved = 1'b0;
      end
    end
  end

  // Register state for status, enables, control words and the request line.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q   <= tmr_status_pkg::RST_STATUS;
      enables_q  <= tmr_status_pkg::RST_ENABLES[tmr_status_pkg::FLAG_W-1:0];
      cc_control <= {NUM_CC{tmr_status_pkg::cc_ctrl_s'(tmr_status_pkg::RST_CC_CONTROL)}};
      irq        <= 1'b0;
    end else if (clk_en) begin
      status_q   <= status_d;
      enables_q  <= enables_d;
      cc_control <= cc_d;
      irq        <= |(flags_q & enables_q);
    end
  end

  // ****************************************************************
  // Interrupt flags
  // ****************************************************************
  logic [tmr_status_pkg::FLAG_W-1:0] flag_set, flag_clr;
  logic                              flag_clr_we;

  // Only the low two lanes carry flag bits; a one clears, a zero is ignored.
  always_comb begin
    flag_set    = tmr_status_pkg::pack_events(events) & PRESENT;
    flag_clr    = wr_lane[tmr_status_pkg::FLAG_W-1:0];
    flag_clr_we = do_write && (wsel == 4'h1);
  end

  tmr_flag_bank #(
    .WIDTH   (tmr_status_pkg::FLAG_W),
    .PRESENT (PRESENT)
  ) u_flags (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clk_en   (clk_en),
    .set_evt  (flag_set),
    .clr_we   (flag_clr_we),
    .clr_bits (flag_clr),
    .flags_q  (flags_q)
  );

  // ****************************************************************
  // Read channel
  // ****************************************************************
  logic                              ar_held_q, ar_held_d, arready_d, rvalid_d;
  logic [tmr_status_pkg::ADDR_W-1:0] araddr_q, araddr_d;
  logic [31:0]                       rdata_d;
  logic [1:0]                        rresp_d;
  logic [3:0]                        rsel;

  // One read at a time; data is taken from the registers in the answering cycle.
  always_comb begin
    ar_held_d = ar_held_q;
    araddr_d  = araddr_q;
    rvalid_d  = s_axi_rvalid;
    rdata_d   = s_axi_rdata;
    rresp_d   = s_axi_rresp;
    rsel      = addr_sel(araddr_q);
    if (s_axi_arvalid && s_axi_arready) begin
      ar_held_d = 1'b1;
      araddr_d  = s_axi_araddr;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (ar_held_q && !s_axi_rvalid) begin
      ar_held_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = tmr_status_pkg::RESP_OKAY;
      case (rsel)
        4'h0:    rdata_d = {16'h0000, status_q};
        4'h1:    rdata_d = {18'h00000, flags_q};
        4'h2:    rdata_d = {18'h00000, enables_q};
        tmr_status_pkg::SEL_UNMAPPED: begin
          rdata_d = 32'h0000_0000;
          rresp_d = tmr_status_pkg::RESP_SLVERR;
        end
        default: rdata_d = {16'h0000, cc_control[3'(rsel - 4'h4)]};
      endcase
    end
    arready_d = !ar_held_d && !rvalid_d;
  end

  // Read channel registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_held_q     <= 1'b0;
      araddr_q      <= '0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= tmr_status_pkg::RESP_OKAY;
    end else if (clk_en) begin
      ar_held_q     <= ar_held_d;
      araddr_q      <= araddr_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid  <= rvalid_d;
      s_axi_rdata   <= rdata_d;
      s_axi_rresp   <= rresp_d;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_cap_level_track: assert property (clk_en
    |=> status_q[7:2] == ($past(status_in.capture_input_pin) & CAP_MASK))
    else $error("capture level bits do not follow the pins");
  a_absent_cap_zero: assert property ((status_q[7:2] & ~CAP_MASK) == 6'h00)
    else $error("missing capture pin reads nonzero");
  a_direction_read: assert property (clk_en ##1 (clk_en && ar_held_q && !s_axi_rvalid && rsel == 4'h0)
    |=> s_axi_rdata[1] == $past(status_in.count_up, 2))
    else $error("direction bit reads wrong");
  a_running_read: assert property (clk_en && ar_held_q && !s_axi_rvalid && rsel == 4'h0
    |=> s_axi_rvalid && s_axi_rdata[0] == $past(status_q[0]) && s_axi_rdata[31:8] == 24'h000000)
    else $error("running bit or upper status bits read wrong");
  a_overwrite_pos: assert property (clk_en && events.capture_overwrite[0] |=> flags_q[3])
    else $error("overwrite event 0 missed bit 3");
  a_cmpcap_pos: assert property (clk_en && events.compare_capture[0] |=> flags_q[2])
    else $error("compare event 0 missed bit 2");
  a_top_bottom_pos: assert property (clk_en && events.counter_top && events.counter_bottom
    |=> flags_q[1:0] == 2'b11)
    else $error("counter top or bottom flag misplaced");
  a_w1c_clears: assert property (clk_en && flag_clr_we && flag_clr[1] && !events.counter_top |=> !flags_q[1])
    else $error("write one did not clear flag");
  a_absent_zero: assert property (((flags_q | enables_q) & ~PRESENT) == '0)
    else $error("absent circuit bit reads nonzero");
  a_irq_gating: assert property (clk_en |=> irq == |($past(flags_q) & $past(enables_q)))
    else $error("interrupt request does not match flags and enables");
  a_reserved_cc: assert property (cc_control[0].reserved == 1'b0)
    else $error("control reserved bit set");

endmodule : timer_status_regs

// *** include/tmr_status_pkg.sv ***
// Constants, field layouts and carrier types of the timer channel status,
// interrupt-flag, interrupt-enable and comparator/capture control registers.
// Assumes a 32-bit AXI4-Lite register bus and one 200 MHz operating clock.
//
// Functional notes
// - Capture-level bits return capture pin levels.
// - Level bits follow capture pins 0 to 5.
// - Missing capture pins read as zero.
// - Direction bit reads 1 up, 0 down.
// - Running bit reads busy state; writes ignored.
// - Flag reads 1 after event; write 0 ignored.
// - Writing 1 clears only that flag.
// - Overwrite flags at bits 3,5,7,9,11,13.
// - Compare/capture flags at bits 2,4,...,12.
// - Top flag bit 1, bottom flag bit 0.
// - Absent circuits' flags and enables read zero.
// - Enables mirror flags, gate them, reset zero.
// - Control register fields per circuit, reset zero.
// - Status layout 7:2 levels, direction resets 1.
package tmr_status_pkg;

  // ****************************************************************
  // Register map and bus answers
  // ****************************************************************
  localparam int          ADDR_W          = 12;
  localparam int          MAX_CC          = 6;
  localparam int          FLAG_W          = 14;
  localparam logic [11:0] OFS_STATUS      = 12'h000;
  localparam logic [11:0] OFS_FLAGS       = 12'h004;
  localparam logic [11:0] OFS_ENABLES     = 12'h008;
  localparam logic [11:0] OFS_CC_BASE     = 12'h010;
  localparam logic [3:0]  SEL_UNMAPPED    = 4'hF;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int          POS_RUNNING     = 0;
  localparam int          POS_DIRECTION   = 1;
  localparam int          POS_CAP_LEVEL   = 2;
  localparam int          POS_BOTTOM_FLAG = 0;
  localparam int          POS_TOP_FLAG    = 1;
  localparam int          POS_CMPCAP_0    = 2;
  localparam int          POS_OVERWRITE_0 = 3;
  localparam int          POS_CC_RSVD     = 7;
  localparam logic [15:0] RST_STATUS      = 16'h0002;
  localparam logic [15:0] RST_FLAGS       = 16'h0000;
  localparam logic [15:0] RST_ENABLES     = 16'h0000;
  localparam logic [15:0] RST_CC_CONTROL  = 16'h0000;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  // Live levels coming from the counter engine and the capture pins.
  typedef struct packed {
    logic [5:0] capture_input_pin;
    logic       count_up;
    logic       counter_running;
  } status_in_s;

  // One-cycle event pulses from the counter and comparator/capture datapath.
  typedef struct packed {
    logic [5:0] capture_overwrite;
    logic [5:0] compare_capture;
    logic       counter_top;
    logic       counter_bottom;
  } events_s;

  // Comparator/capture control word, packed in register bit order.
  typedef struct packed {
    logic       capture_sync_select;
    logic [2:0] buffer_load_mode;
    logic [1:0] trigger_source;
    logic [1:0] trigger_edge;
    logic       reserved;
    logic       paired_match_output;
    logic       software_output_level;
    logic [2:0] output_wave_mode;
    logic       output_inversion;
    logic       compare_or_capture_select;
  } cc_ctrl_s;

  // Interleaves the event pulses into the flag register layout.
  function automatic logic [FLAG_W-1:0] pack_events(input events_s ev);
    logic [FLAG_W-1:0] v;
    v = '0;
    v[POS_BOTTOM_FLAG] = ev.counter_bottom;
    v[POS_TOP_FLAG]    = ev.counter_top;
    for (int m = 0; m < MAX_CC; m++) begin
      v[POS_CMPCAP_0 + 2*m]    = ev.compare_capture[m];
      v[POS_OVERWRITE_0 + 2*m] = ev.capture_overwrite[m];
    end
    return v;
  endfunction : pack_events

  // Flag and enable bits that exist for a channel with n circuits.
  function automatic logic [FLAG_W-1:0] present_mask(input int n);
    logic [FLAG_W-1:0] v;
    v = '0;
    v[POS_BOTTOM_FLAG] = 1'b1;
    v[POS_TOP_FLAG]    = 1'b1;
    for (int m = 0; m < MAX_CC; m++) begin
      v[POS_CMPCAP_0 + 2*m]    = (m < n);
      v[POS_OVERWRITE_0 + 2*m] = (m < n);
    end
    return v;
  endfunction : present_mask

endpackage : tmr_status_pkg

// *** hw/tmr_flag_bank.sv ***
// Sticky interrupt-cause flags with write-one-to-clear.
// Assumes one-cycle event pulses and a clear strobe from the register slave.
module tmr_flag_bank #(
  parameter int                 WIDTH   = 14,
  parameter logic [WIDTH-1:0]   PRESENT = '1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] set_evt,
  input  wire logic             clr_we,
  input  wire logic [WIDTH-1:0] clr_bits,
  output logic      [WIDTH-1:0] flags_q
);

  logic [WIDTH-1:0] flags_d;

  // An event in the clearing cycle survives, so a clear never drops a cause.
  always_comb begin
    flags_d = flags_q;
    if (clr_we) begin
      flags_d = flags_d & ~clr_bits;
    end
    flags_d = (flags_d | set_evt) & PRESENT;
  end

  // Flag storage; frozen while the clock enable is low.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= '0;
    end else if (clk_en) begin
      flags_q <= flags_d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_set_beats_clear: assert property (clk_en && clr_we && (set_evt != '0)
    |=> ((flags_q & $past(set_evt) & PRESENT) == ($past(set_evt) & PRESENT)))
    else $error("event lost against a simultaneous clear");
  a_write_zero_keeps: assert property (clk_en && (set_evt == '0)
    |=> ((flags_q & ~$past(clr_bits & {WIDTH{clr_we}}))
         == ($past(flags_q) & ~$past(clr_bits & {WIDTH{clr_we}}))))
    else $error("flag changed without a one written");

endmodule : tmr_flag_bank

// *** testbench/pin_model.sv ***
// Model of the capture pins and the counter engine beside the register slave.
// Assumes the bench steers levels and event requests just after rising edges.
module pin_model (
  input  wire logic                  aclk,
  input  wire logic [5:0]            pin_level,
  input  wire logic                  up,
  input  wire logic                  run,
  input  wire logic [13:0]           fire,
  output tmr_status_pkg::status_in_s status_in,
  output tmr_status_pkg::events_s    events
);
  timeunit 1ns;
  timeprecision 1ps;
  // Levels change only at edges, so the block never sees a glitch mid-cycle.
  always_ff @(posedge aclk) begin
    status_in <= {pin_level, up, run};
    events    <= fire; // A request held one cycle gives a one-cycle event.
  end
endmodule : pin_model

// *** testbench/testbench.sv ***
// Self-checking bench of the timer channel register slave with random stimulus.
// Assumes the pin model drives status and events; clk_en drops once to check the freeze.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic                            irq, up, run;
  logic [11:0]                     s_axi_awaddr, s_axi_araddr;
  logic [31:0]                     s_axi_wdata, s_axi_rdata, rd, exp_word;
  logic [3:0]                      s_axi_wstrb;
  logic [1:0]                      s_axi_bresp, s_axi_rresp, resp;
  logic [5:0]                      pin_level;
  logic [7:0]                      s;
  logic [13:0]                     fire, ev, en;
  tmr_status_pkg::status_in_s      status_in;
  tmr_status_pkg::events_s         events;
  tmr_status_pkg::cc_ctrl_s [5:0]  cc_control;
  int                              fail_count, comparisons;

  timer_status_regs dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .status_in(status_in),
    .events(events), .cc_control(cc_control), .irq(irq));
  pin_model partner (.aclk(aclk), .pin_level(pin_level), .up(up), .run(run), .fire(fire),
    .status_in(status_in), .events(events));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Flag word expected from events given in carrier order.
  function automatic logic [31:0] flags_of(input logic [13:0] e);
    logic [31:0] f;
    f = '0;
    f[1:0] = e[1:0];
    for (int m = 0; m < 6; m++) begin
      f[2+2*m] = e[2+m];
      f[3+2*m] = e[8+m];
    end
    return f;
  endfunction : flags_of

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, want);
    end
  endtask : check

  // Each task ends one edge late so no strobe is driven twice in one step.
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic a_done;
    a_done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!a_done && s_axi_arready === 1'b1) begin
        a_done = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_read

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] want);
    axi_read(a, rd, resp);
    check({rd[29:0], resp}, {want[29:0], tmr_status_pkg::RESP_OKAY});
    check(rd, want);
  endtask : rd_chk

  // One-cycle event, then time for flag and irq to settle.
  task automatic pulse(input logic [13:0] e);
    fire <= e;
    @(posedge aclk);
    fire <= '0;
    repeat (4) @(posedge aclk);
  endtask : pulse

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // ****************************************************************
  // Clock, watchdog and test sequence
  // ****************************************************************
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // The run needs about 750 cycles; this margin only catches a hang.
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    complete_run();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pin_level, run, fire} = '0;
    {clk_en, up, s_axi_wstrb} = 6'h3F;
    void'($urandom(30));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(tmr_status_pkg::OFS_STATUS, 32'h0000_0002);
    rd_chk(tmr_status_pkg::OFS_FLAGS, 32'h0000_0000);
    rd_chk(tmr_status_pkg::OFS_ENABLES, 32'h0000_0000);
    rd_chk(tmr_status_pkg::OFS_CC_BASE + 12'h014, 32'h0000_0000);
    // Live levels, with writes to the read-only word in between.
    for (int i = 0; i < 8; i++) begin
      s = (i == 0) ? 8'hA9 : 8'($urandom);
      {pin_level, up, run} <= s;
      axi_write(tmr_status_pkg::OFS_STATUS, 32'h0000_FFFF, resp);
      check({30'h0, resp}, {30'h0, tmr_status_pkg::RESP_OKAY});
      rd_chk(tmr_status_pkg::OFS_STATUS, {24'h0, s});
    end
    // Walk each event to its flag position, then try write 0 and write 1.
    for (int k = 0; k < 14; k++) begin
      ev = 14'h1 << k;
      pulse(ev);
      rd_chk(tmr_status_pkg::OFS_FLAGS, flags_of(ev));
      axi_write(tmr_status_pkg::OFS_FLAGS, 32'h0, resp);
      rd_chk(tmr_status_pkg::OFS_FLAGS, flags_of(ev));
      axi_write(tmr_status_pkg::OFS_FLAGS, flags_of(ev), resp);
      rd_chk(tmr_status_pkg::OFS_FLAGS, 32'h0);
    end
    // Random partial clears, reserved bits written as ones.
    for (int i = 0; i < 6; i++) begin
      ev = 14'($urandom);
      en = 14'($urandom);
      pulse(ev);
      axi_write(tmr_status_pkg::OFS_FLAGS, {18'h3FFFF, en}, resp);
      rd_chk(tmr_status_pkg::OFS_FLAGS, flags_of(ev) & ~{18'h0, en});
      axi_write(tmr_status_pkg::OFS_FLAGS, 32'h0000_3FFF, resp);
    end
    // A frozen block keeps its state, so an event arriving then is not recorded.
    clk_en <= 1'b0;
    pulse(14'h0003);
    clk_en <= 1'b1;
    rd_chk(tmr_status_pkg::OFS_FLAGS, 32'h0000_0000);
    // Flags are cleared before enabling, so a stale cause cannot raise irq.
    for (int i = 0; i < 8; i++) begin
      en = (i == 0) ? 14'h3FFF : 14'($urandom);
      axi_write(tmr_status_pkg::OFS_FLAGS, 32'h0000_FFFF, resp);
      axi_write(tmr_status_pkg::OFS_ENABLES, {18'h3FFFF, en}, resp);
      rd_chk(tmr_status_pkg::OFS_ENABLES, {18'h0, en});
      check({31'h0, irq}, 32'h0);
      ev = 14'($urandom);
      exp_word = flags_of(ev);
      pulse(ev);
      check({31'h0, irq}, {31'h0, |(exp_word[13:0] & en)});
    end
    for (int m = 0; m < 6; m++) begin
      exp_word = $urandom;
      axi_write(tmr_status_pkg::OFS_CC_BASE + 12'(4 * m), exp_word, resp);
      rd_chk(tmr_status_pkg::OFS_CC_BASE + 12'(4 * m), {16'h0, exp_word[15:8], 1'b0, exp_word[6:0]});
      check({16'h0, cc_control[m] & 16'hFF7F}, exp_word & 32'h0000_FF7F);
    end
    // Unmapped places answer with an error and zero data.
    axi_read(12'h028, rd, resp);
    check({rd[29:0], resp}, {30'h0, tmr_status_pkg::RESP_SLVERR});
    axi_write(12'h0FC, 32'h0000_FFFF, resp);
    check({30'h0, resp}, {30'h0, tmr_status_pkg::RESP_SLVERR});
    complete_run();
  end
endmodule : testbench
